/* File: uhs_params.svh */
`ifndef UHS_PARAMS_SVH
`define UHS_PARAMS_SVH

`define UHS_SLAVE_ADDR    7'h74
`define UHS_FIFO_DEPTH    6'h20
`define UHS_NUM_FIFO      4
`define UHS_BYTE_BITS     4'h8

// selector codes, first data byte of a write transaction
`define UHS_SEL_EP0_TX    3'h0
`define UHS_SEL_HUB1_TX   3'h1
`define UHS_SEL_FUNC1_TX  3'h2
`define UHS_SEL_STATUS    3'h3
`define UHS_SEL_EP0_RX    3'h4
`define UHS_SEL_EP1_RX    3'h5

// status byte bit positions
`define UHS_ST_EP0_RX     0
`define UHS_ST_EP1_RX     1
`define UHS_ST_PORT_CHG   2

// controller serial clock timing: one bit is four quarters
`define UHS_CLK_NS        10
`define UHS_QUARTER_NS    100
`define UHS_QUARTER_CYC   ((`UHS_QUARTER_NS + `UHS_CLK_NS - 1) / `UHS_CLK_NS)

`endif

/* File: uhs_pkg.sv */
package uhs_pkg;

  typedef enum logic [1:0] {
    UHS_OP_START,
    UHS_OP_WRITE,
    UHS_OP_READ,
    UHS_OP_STOP
  } uhs_op_t;

  typedef enum logic [2:0] {
    UHS_DS_IDLE,
    UHS_DS_ADDR,
    UHS_DS_WDATA,
    UHS_DS_WACK,
    UHS_DS_RDATA,
    UHS_DS_RACK
  } uhs_dev_state_t;

  typedef enum logic [1:0] {
    UHS_MS_IDLE,
    UHS_MS_START,
    UHS_MS_BIT,
    UHS_MS_STOP
  } uhs_mst_state_t;

endpackage : uhs_pkg

/* File: uhs_if.sv */
`timescale 1ns/10ps
interface uhs_if;
  logic scl_oe_c;
  logic sda_oe_c;
  logic sda_oe_d;
  logic int_oe_d;
  logic serial_clock_line;
  logic serial_data_line;
  logic interrupt_request_n;

  // open-drain wires with pull-ups: low whenever any party drives
  assign serial_clock_line   = ~scl_oe_c;
  assign serial_data_line    = ~(sda_oe_c | sda_oe_d);
  assign interrupt_request_n = ~int_oe_d;

  modport device (
    input  serial_clock_line,
    input  serial_data_line,
    output sda_oe_d,
    output int_oe_d
  );

  modport controller (
    input  serial_clock_line,
    input  serial_data_line,
    input  interrupt_request_n,
    output scl_oe_c,
    output sda_oe_c
  );
endinterface : uhs_if

/* File: uhs_device.sv */
`timescale 1ns/10ps
`include "uhs_params.svh"

module uhs_device
  import uhs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  uhs_if.device           link,
  input  wire logic       rx_push,
  input  wire logic [7:0] rx_data,
  output logic            rx_ready,
  input  wire logic       tx_pop,
  input  wire logic [1:0] tx_sel,
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  output logic [2:0]      tx_nonempty,
  input  wire logic       ep1_ack_load,
  input  wire logic [7:0] ep1_ack_data,
  input  wire logic       port_change
);

  logic scl_s1, scl_s2, scl_d;
  logic sda_s1, sda_s2, sda_d;
  logic rise, fall, start_ev, stop_ev;

  // only the second stage and its delayed copy feed edge detection
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_s1 <= link.serial_clock_line;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= link.serial_data_line;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end
  assign rise     = scl_s2 & ~scl_d;
  assign fall     = ~scl_s2 & scl_d;
  assign start_ev = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_ev  = scl_s2 & scl_d & ~sda_d & sda_s2;
  uhs_dev_state_t state, next_state;
  logic [3:0] bcnt, next_bcnt;
  logic [7:0] sh, next_sh;
  logic       rw, next_rw;
  logic       first, next_first;
  logic [2:0] sel, next_sel;
  logic       sda_oe, next_sda_oe;
  logic       ser_push, ser_pop_rx, rd_status, rd_ep1, do_load;
  logic [1:0] push_idx;
  logic [7:0] fetch;

  logic [7:0] mem [`UHS_NUM_FIFO][32];
  logic [4:0] wp [`UHS_NUM_FIFO];
  logic [4:0] rp [`UHS_NUM_FIFO];
  logic [5:0] fcnt [`UHS_NUM_FIFO];
  logic [4:0] next_wp [`UHS_NUM_FIFO];
  logic [4:0] next_rp [`UHS_NUM_FIFO];
  logic [5:0] next_fcnt [`UHS_NUM_FIFO];
  logic [3:0] push, pop;
  logic [2:0] flags, next_flags;
  logic [7:0] ep1_reg, next_ep1_reg;
  logic       next_tx_valid;
  logic [7:0] next_tx_data;
  logic       int_oe;
  assign push_idx = sel[1:0] + 2'h1;
  always_comb begin
    unique case (sel)
      `UHS_SEL_STATUS: fetch = {5'h00, flags};
      `UHS_SEL_EP0_RX: fetch = (fcnt[0] != 6'h00) ? mem[0][rp[0]] : 8'h00;
      `UHS_SEL_EP1_RX: fetch = ep1_reg;
      default:         fetch = 8'h00;
    endcase
  end
  always_comb begin
    next_state  = state;
    next_bcnt   = bcnt;
    next_sh     = sh;
    next_rw     = rw;
    next_first  = first;
    next_sel    = sel;
    next_sda_oe = sda_oe;
    ser_push    = 1'b0;
    ser_pop_rx  = 1'b0;
    rd_status   = 1'b0;
    rd_ep1      = 1'b0;
    do_load     = 1'b0;
    if (start_ev) begin
      next_state  = UHS_DS_ADDR;
      next_bcnt   = 4'h0;
      next_first  = 1'b1;
      next_sda_oe = 1'b0;
    end else if (stop_ev) begin
      next_state  = UHS_DS_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      unique case (state)
        UHS_DS_IDLE: ;
        UHS_DS_ADDR, UHS_DS_WDATA: begin
          if (rise) begin
            next_sh   = {sh[6:0], sda_s2};
            next_bcnt = bcnt + 4'h1;
          end else if (fall && bcnt == `UHS_BYTE_BITS) begin
            if (state == UHS_DS_ADDR) begin
              if (sh[7:1] == `UHS_SLAVE_ADDR) begin
                next_rw     = sh[0];
                next_sda_oe = 1'b1;
                next_state  = UHS_DS_WACK;
              end else begin
                next_state = UHS_DS_IDLE;
              end
            end else if (first) begin
              next_sel    = sh[2:0];
              next_first  = 1'b0;
              next_sda_oe = 1'b1;
              next_state  = UHS_DS_WACK;
            end else if (sel < `UHS_SEL_STATUS && fcnt[push_idx] != `UHS_FIFO_DEPTH) begin
              ser_push    = 1'b1;
              next_sda_oe = 1'b1;
              next_state  = UHS_DS_WACK;
            end else begin
              // full fifo or read-only target: refuse with no ack
              next_state = UHS_DS_IDLE;
            end
          end
        end
        UHS_DS_WACK: begin
          if (fall) begin
            next_bcnt = 4'h0;
            if (rw) begin
              do_load = 1'b1;
            end else begin
              next_sda_oe = 1'b0;
              next_state  = UHS_DS_WDATA;
            end
          end
        end
        UHS_DS_RDATA: begin
          if (rise) begin
            next_bcnt = bcnt + 4'h1;
          end else if (fall) begin
            if (bcnt == `UHS_BYTE_BITS) begin
              next_sda_oe = 1'b0;
              next_state  = UHS_DS_RACK;
            end else begin
              next_sh     = {sh[6:0], 1'b0};
              next_sda_oe = ~sh[6];
            end
          end
        end
        UHS_DS_RACK: begin
          if (rise && sda_s2) begin
            next_state = UHS_DS_IDLE;
          end else if (fall) begin
            next_bcnt = 4'h0;
            do_load   = 1'b1;
          end
        end
      endcase
    end
    if (do_load) begin
      next_sh     = fetch;
      next_sda_oe = ~fetch[7];
      next_state  = UHS_DS_RDATA;
      ser_pop_rx  = (sel == `UHS_SEL_EP0_RX) && (fcnt[0] != 6'h00);
      rd_status   = (sel == `UHS_SEL_STATUS);
      rd_ep1      = (sel == `UHS_SEL_EP1_RX);
    end
  end
  always_comb begin
    push[0] = rx_push && (fcnt[0] != `UHS_FIFO_DEPTH);
    pop[0]  = ser_pop_rx;
    for (int i = 1; i < `UHS_NUM_FIFO; i++) begin
      push[i] = ser_push && (push_idx == 2'(i));
      pop[i]  = tx_pop && (tx_sel == 2'(i - 1)) && (fcnt[i] != 6'h00);
    end
    for (int i = 0; i < `UHS_NUM_FIFO; i++) begin
      next_wp[i]   = wp[i] + 5'(push[i]);
      next_rp[i]   = rp[i] + 5'(pop[i]);
      next_fcnt[i] = fcnt[i] + 6'(push[i]) - 6'(pop[i]);
    end
    next_tx_valid = |pop[3:1];
    next_tx_data  = tx_data;
    if (|pop[3:1]) next_tx_data = mem[tx_sel + 2'h1][rp[tx_sel + 2'h1]];
    next_ep1_reg = ep1_ack_load ? ep1_ack_data : ep1_reg;
    // set wins over a clear landing in the same cycle
    next_flags = flags;
    if (rd_status) begin
      next_flags[`UHS_ST_EP0_RX]   = 1'b0;
      next_flags[`UHS_ST_PORT_CHG] = 1'b0;
    end
    if (rd_ep1) next_flags[`UHS_ST_EP1_RX] = 1'b0;
    if (push[0]) next_flags[`UHS_ST_EP0_RX] = 1'b1;
    if (ep1_ack_load) next_flags[`UHS_ST_EP1_RX] = 1'b1;
    if (port_change) next_flags[`UHS_ST_PORT_CHG] = 1'b1;
  end
  always_ff @(posedge clk) begin
    for (int i = 0; i < `UHS_NUM_FIFO; i++) begin
      if (push[i]) mem[i][wp[i]] <= (i == 0) ? rx_data : sh;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state       <= UHS_DS_IDLE;
      bcnt        <= 4'h0;
      sh          <= 8'h00;
      rw          <= 1'b0;
      first       <= 1'b1;
      sel         <= `UHS_SEL_STATUS;
      sda_oe      <= 1'b0;
      flags       <= 3'h0;
      ep1_reg     <= 8'h00;
      int_oe      <= 1'b0;
      tx_valid    <= 1'b0;
      tx_data     <= 8'h00;
      rx_ready    <= 1'b1;
      tx_nonempty <= 3'h0;
      for (int i = 0; i < `UHS_NUM_FIFO; i++) begin
        wp[i]   <= 5'h00;
        rp[i]   <= 5'h00;
        fcnt[i] <= 6'h00;
      end
    end else begin
      state       <= next_state;
      bcnt        <= next_bcnt;
      sh          <= next_sh;
      rw          <= next_rw;
      first       <= next_first;
      sel         <= next_sel;
      sda_oe      <= next_sda_oe;
      flags       <= next_flags;
      ep1_reg     <= next_ep1_reg;
      int_oe      <= |next_flags;
      tx_valid    <= next_tx_valid;
      tx_data     <= next_tx_data;
      rx_ready    <= next_fcnt[0] != `UHS_FIFO_DEPTH;
      tx_nonempty <= {next_fcnt[3] != 6'h00, next_fcnt[2] != 6'h00, next_fcnt[1] != 6'h00};
      for (int i = 0; i < `UHS_NUM_FIFO; i++) begin
        wp[i]   <= next_wp[i];
        rp[i]   <= next_rp[i];
        fcnt[i] <= next_fcnt[i];
      end
    end
  end
  // no clock driver exists on this end at all
  assign link.sda_oe_d = sda_oe;
  assign link.int_oe_d = int_oe;

endmodule : uhs_device

/* File: uhs_controller.sv */
`timescale 1ns/10ps
`include "uhs_params.svh"

module uhs_controller
  import uhs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  uhs_if.controller       link,
  input  wire logic       cmd_valid,
  input  wire uhs_op_t    cmd_op,
  input  wire logic [7:0] cmd_data,
  input  wire logic       cmd_ack,
  output logic            cmd_ready,
  output logic            done,
  output logic [7:0]      rd_data,
  output logic            ack_seen,
  output logic            irq
);

  localparam logic [7:0] QUARTER_LAST = 8'(`UHS_QUARTER_CYC - 1);

  logic sda_s1, sda_s2, int_s1, int_s2;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      int_s1 <= 1'b1;
      int_s2 <= 1'b1;
    end else begin
      sda_s1 <= link.serial_data_line;
      sda_s2 <= sda_s1;
      int_s1 <= link.interrupt_request_n;
      int_s2 <= int_s1;
    end
  end

  uhs_mst_state_t state, next_state;
  logic [7:0] qcnt, next_qcnt;
  logic [1:0] ph, next_ph;
  logic [3:0] bitn, next_bitn;
  logic [7:0] sh, next_sh;
  logic       rd, next_rd;
  logic       ack_drive, next_ack_drive;
  logic       scl_oe, next_scl_oe;
  logic       sda_oe, next_sda_oe;
  logic       next_ready, next_done, next_ack_seen;
  logic [7:0] next_rd_data;
  logic       tick;

  assign tick = (qcnt == QUARTER_LAST);

  always_comb begin
    next_state     = state;
    next_qcnt      = (state == UHS_MS_IDLE || tick) ? 8'h00 : qcnt + 8'h01;
    next_ph        = ph;
    next_bitn      = bitn;
    next_sh        = sh;
    next_rd        = rd;
    next_ack_drive = ack_drive;
    next_scl_oe    = scl_oe;
    next_sda_oe    = sda_oe;
    next_ready     = cmd_ready;
    next_done      = 1'b0;
    next_ack_seen  = ack_seen;
    next_rd_data   = rd_data;
    unique case (state)
      UHS_MS_IDLE: begin
        if (cmd_valid) begin
          next_ready = 1'b0;
          next_ph    = 2'h0;
          next_bitn  = 4'h0;
          unique case (cmd_op)
            UHS_OP_START: begin
              next_sh    = cmd_data;
              next_state = UHS_MS_START;
            end
            UHS_OP_WRITE: begin
              next_sh    = cmd_data;
              next_rd    = 1'b0;
              next_state = UHS_MS_BIT;
            end
            UHS_OP_READ: begin
              next_rd        = 1'b1;
              next_ack_drive = cmd_ack;
              next_state     = UHS_MS_BIT;
            end
            UHS_OP_STOP: begin
              next_state = UHS_MS_STOP;
            end
          endcase
        end
      end
      UHS_MS_START: begin
        // also serves as a repeated start when the clock is low
        if (tick) begin
          next_ph = ph + 2'h1;
          unique case (ph)
            2'h0: next_sda_oe = 1'b0;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b1;
            2'h3: begin
              next_scl_oe = 1'b1;
              next_rd     = 1'b0;
              next_state  = UHS_MS_BIT;  // address byte follows at once
            end
          endcase
        end
      end
      UHS_MS_BIT: begin
        if (tick) begin
          next_ph = ph + 2'h1;
          unique case (ph)
            2'h0: begin
              if (bitn < `UHS_BYTE_BITS) begin
                next_sda_oe = rd ? 1'b0 : ~sh[7];
              end else begin
                next_sda_oe = rd ? ack_drive : 1'b0;
              end
            end
            2'h1: next_scl_oe = 1'b0;
            2'h2: begin
              if (bitn < `UHS_BYTE_BITS) begin
                next_sh = {sh[6:0], sda_s2};
              end else begin
                next_ack_seen = ~sda_s2;
              end
            end
            2'h3: begin
              next_scl_oe = 1'b1;
              if (bitn == `UHS_BYTE_BITS) begin
                next_done    = 1'b1;
                next_rd_data = sh;
                next_ready   = 1'b1;
                next_state   = UHS_MS_IDLE;
              end else begin
                next_bitn = bitn + 4'h1;
              end
            end
          endcase
        end
      end
      UHS_MS_STOP: begin
        if (tick) begin
          next_ph = ph + 2'h1;
          unique case (ph)
            2'h0: next_sda_oe = 1'b1;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b0;
            2'h3: begin
              next_done  = 1'b1;
              next_ready = 1'b1;
              next_state = UHS_MS_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state     <= UHS_MS_IDLE;
      qcnt      <= 8'h00;
      ph        <= 2'h0;
      bitn      <= 4'h0;
      sh        <= 8'h00;
      rd        <= 1'b0;
      ack_drive <= 1'b0;
      scl_oe    <= 1'b0;
      sda_oe    <= 1'b0;
      cmd_ready <= 1'b1;
      done      <= 1'b0;
      ack_seen  <= 1'b0;
      rd_data   <= 8'h00;
      irq       <= 1'b0;
    end else begin
      state     <= next_state;
      qcnt      <= next_qcnt;
      ph        <= next_ph;
      bitn      <= next_bitn;
      sh        <= next_sh;
      rd        <= next_rd;
      ack_drive <= next_ack_drive;
      scl_oe    <= next_scl_oe;
      sda_oe    <= next_sda_oe;
      cmd_ready <= next_ready;
      done      <= next_done;
      ack_seen  <= next_ack_seen;
      rd_data   <= next_rd_data;
      irq       <= ~int_s2;
    end
  end

  assign link.scl_oe_c = scl_oe;
  assign link.sda_oe_c = sda_oe;

endmodule : uhs_controller

/* File: uhs_link_properties.sv */
`timescale 1ns/10ps
`include "uhs_params.svh"

module uhs_link_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_oe_c,
  input wire logic sda_oe_c,
  input wire logic sda_oe_d,
  input wire logic int_oe_d,
  input wire logic serial_clock_line,
  input wire logic serial_data_line,
  input wire logic interrupt_request_n
);
  logic       scl_q, sda_q, first, rd, ign;
  logic       next_first, next_rd, next_ign;
  logic [3:0] cnt, next_cnt;
  logic [7:0] shreg, next_shreg;
  logic       start, stop, rise, fall, match;

  assign start = scl_q & serial_clock_line & sda_q & ~serial_data_line;
  assign stop  = scl_q & serial_clock_line & ~sda_q & serial_data_line;
  assign rise  = ~scl_q & serial_clock_line;
  assign fall  = scl_q & ~serial_clock_line;
  assign match = (shreg[7:1] == `UHS_SLAVE_ADDR);

  // bit position within the byte, 1..9 while a bit's clock is high; 0 after reset and after a start
  always_comb begin
    next_cnt   = cnt;
    next_shreg = shreg;
    next_first = first;
    next_rd    = rd;
    next_ign   = ign;
    if (start) begin
      next_cnt   = 4'h0;
      next_first = 1'b1;
      next_rd    = 1'b0;
      next_ign   = 1'b0;
    end else if (rise) begin
      next_cnt = (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
      if (cnt != 4'h8) begin
        next_shreg = {shreg[6:0], serial_data_line};
      end
    end else if (fall && first && cnt == 4'h9) begin
      next_first = 1'b0;
      next_rd    = match & shreg[0];
      next_ign   = ~match;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt   <= 4'h0;
      shreg <= 8'h00;
      first <= 1'b0;
      rd    <= 1'b0;
      ign   <= 1'b0;
    end else begin
      scl_q <= serial_clock_line;
      sda_q <= serial_data_line;
      cnt   <= next_cnt;
      shreg <= next_shreg;
      first <= next_first;
      rd    <= next_rd;
      ign   <= next_ign;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_scl_high;
    $rose(serial_clock_line) |-> !scl_oe_c ##1 serial_clock_line [*8];
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high phase too short");

  property p_dev_sda_low;
    $changed(sda_oe_d) |-> !serial_clock_line && !$past(serial_clock_line);
  endproperty
  a_dev_sda_low: assert property (p_dev_sda_low) else $error("device data moved with clock high");

  property p_start_clk;
    start |-> ##[5:15] !serial_clock_line;
  endproperty
  a_start_clk: assert property (p_start_clk) else $error("no clock after start");

  // the stop's own clock pulse already opened a new count
  property p_stop_byte;
    stop |-> cnt == 4'h1;
  endproperty
  a_stop_byte: assert property (p_stop_byte) else $error("stop inside a byte");

  property p_addr_ack;
    serial_clock_line && scl_q && first && cnt == 4'h9 && match |-> sda_oe_d && !sda_oe_c;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

  property p_addr_nak;
    serial_clock_line && scl_q && first && cnt == 4'h9 && !match |-> !sda_oe_d;
  endproperty
  a_addr_nak: assert property (p_addr_nak) else $error("foreign address acknowledged");

  property p_ignored;
    ign |-> !sda_oe_d;
  endproperty
  a_ignored: assert property (p_ignored) else $error("device drove data after foreign address");

  // looked at as the clock falls: the pulse of a stop never falls
  property p_rd_bits;
    scl_q && !serial_clock_line && rd && !first && cnt != 4'h9 |-> !sda_oe_c;
  endproperty
  a_rd_bits: assert property (p_rd_bits) else $error("controller drove data during read bits");

  property p_rd_ack;
    serial_clock_line && scl_q && rd && !first && cnt == 4'h9 |-> !sda_oe_d;
  endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("device drove data in read acknowledge");

  property p_int_release;
    $rose(interrupt_request_n) |-> rd && !int_oe_d;
  endproperty
  a_int_release: assert property (p_int_release) else $error("interrupt released outside a read");

endmodule : uhs_link_properties

/* File: test_usb_hub_uc_serial_fifo_port.sv */
`timescale 1ns/10ps
`include "uhs_params.svh"

module test_usb_hub_uc_serial_fifo_port
  import uhs_pkg::*;
;
  logic        clk, resetn, rx_push, tx_pop, ep1_ack_load, port_change, cmd_valid, cmd_ack;
  logic [7:0]  rx_data, ep1_ack_data, cmd_data, tx_data, rd_data, bad, e;
  logic [1:0]  tx_sel;
  uhs_op_t     cmd_op;
  logic        rx_ready, tx_valid, cmd_ready, done, ack_seen, irq;
  logic [2:0]  tx_nonempty;
  logic [10:0] exp_q[$];
  logic [10:0] note;
  logic [7:0]  txq[$];
  logic [7:0]  r[3];
  int          fails, total_checks, n;

  uhs_if i_uhs_if ();
  uhs_device i_uhs_device (.clk(clk), .resetn(resetn), .link(i_uhs_if), .rx_push(rx_push), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_pop(tx_pop), .tx_sel(tx_sel), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_nonempty(tx_nonempty), .ep1_ack_load(ep1_ack_load), .ep1_ack_data(ep1_ack_data),
    .port_change(port_change));
  uhs_controller i_uhs_controller (.clk(clk), .resetn(resetn), .link(i_uhs_if), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack), .cmd_ready(cmd_ready), .done(done),
    .rd_data(rd_data), .ack_seen(ack_seen), .irq(irq));
  uhs_link_properties i_uhs_link_properties (.clk(clk), .resetn(resetn), .scl_oe_c(i_uhs_if.scl_oe_c),
    .sda_oe_c(i_uhs_if.sda_oe_c), .sda_oe_d(i_uhs_if.sda_oe_d), .int_oe_d(i_uhs_if.int_oe_d),
    .serial_clock_line(i_uhs_if.serial_clock_line), .serial_data_line(i_uhs_if.serial_data_line),
    .interrupt_request_n(i_uhs_if.interrupt_request_n));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic err(input string m);
    fails++;
    $display("FAIL %0t %s", $time, m);
  endtask : err

  task automatic cmp_bit(input logic g, input logic x, input string m);
    total_checks++;
    if (g !== x) err(m);
  endtask : cmp_bit

  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] x, input string m);
    total_checks++;
    if (g !== x) err(m);
  endtask : cmp_byte

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // note: {check ack, check data, ack, data}
  task automatic op(input uhs_op_t o, input logic [7:0] d, input logic a, input logic [10:0] nt);
    int k;
    exp_q.push_back(nt);
    @(negedge clk);
    while (cmd_ready !== 1'b1) @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op    = o;
    cmd_data  = d;
    cmd_ack   = a;
    @(negedge clk);
    cmd_valid = 1'b0;
    for (k = 0; k < 2000 && done !== 1'b1; k++) @(negedge clk);
    if (k == 2000) err("operation hung");
  endtask : op

  task automatic sta(input logic [7:0] a, input logic x);
    op(UHS_OP_START, a, 1'b0, {2'b10, x, 8'h00});
  endtask : sta

  task automatic wr(input logic [7:0] d, input logic x);
    op(UHS_OP_WRITE, d, 1'b0, {2'b10, x, 8'h00});
  endtask : wr

  task automatic rd(input logic [7:0] x, input logic a);
    op(UHS_OP_READ, 8'h00, a, {2'b11, a, x});
  endtask : rd

  task automatic sto();
    op(UHS_OP_STOP, 8'h00, 1'b0, 11'h000);
  endtask : sto

  // one pop past the expected count: an empty fifo must stay silent
  task automatic pop(input logic [1:0] s, input int cnt);
    for (int i = 0; i <= cnt; i++) begin
      @(negedge clk);
      tx_pop = 1'b1;
      tx_sel = s;
    end
    @(negedge clk);
    tx_pop = 1'b0;
    repeat (3) @(negedge clk);
  endtask : pop

  task automatic chk_irq(input logic x);
    repeat (8) @(negedge clk);
    cmp_bit(irq, x, "interrupt level");
  endtask : chk_irq

  always @(negedge clk) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) begin
        err("unexpected completion");
      end else begin
        note = exp_q.pop_front();
        if (note[10]) cmp_bit(ack_seen, note[8], "acknowledge");
        if (note[9]) cmp_byte(rd_data, note[7:0], "read byte");
      end
    end
    if (tx_valid === 1'b1) begin
      if (txq.size() == 0) err("pop from empty fifo");
      else cmp_byte(tx_data, txq.pop_front(), "fifo byte");
    end
  end

  initial begin
    repeat (90000) @(posedge clk);
    err("watchdog expired");
    conclude();
  end

  initial begin
    {resetn, rx_push, tx_pop, ep1_ack_load, port_change, cmd_valid, cmd_ack} = 7'h00;
    {rx_data, ep1_ack_data, cmd_data} = 24'h000000;
    tx_sel = 2'h0;
    cmd_op = UHS_OP_START;
    void'($urandom(32'h8E2D));
    repeat (16) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    cmp_bit(irq, 1'b0, "irq after reset");
    cmp_bit(rx_ready, 1'b1, "rx ready after reset");
    cmp_byte({5'h00, tx_nonempty}, 8'h00, "fifos empty after reset");
    bad = $urandom;
    if (bad[7:1] == `UHS_SLAVE_ADDR) bad[7] = ~bad[7];
    sta(bad, 1'b0);
    wr(8'h00, 1'b0);
    sto();
    for (int s = 0; s < 3; s++) begin
      n = (s == 0) ? 32 : 1 + $urandom % 4;
      sta(8'hE8, 1'b1);
      wr(s[7:0], 1'b1);
      for (int i = 0; i < n; i++) begin
        e = $urandom;
        txq.push_back(e);
        wr(e, 1'b1);
      end
      if (s == 0) wr(8'hA5, 1'b0);
      sto();
      cmp_byte({5'h00, tx_nonempty}, 8'h01 << s, "fifo nonempty");
      pop(s[1:0], n);
      cmp_byte({5'h00, tx_nonempty}, 8'h00, "fifo drained");
    end
    // writes to a read-only selector end the transfer
    sta(8'hE8, 1'b1);
    wr(8'h03, 1'b1);
    wr(8'h55, 1'b0);
    wr(8'h66, 1'b0);
    sto();
    for (int i = 0; i < 3; i++) begin
      r[i] = $urandom;
      @(negedge clk);
      rx_push = 1'b1;
      rx_data = r[i];
      @(negedge clk);
      rx_push = 1'b0;
    end
    chk_irq(1'b1);
    sta(8'hE8, 1'b1);
    wr(8'h04, 1'b1);
    sta(8'hE9, 1'b1);
    for (int i = 0; i < 3; i++) rd(r[i], 1'b1);
    rd(8'h00, 1'b0);
    sto();
    sta(8'hE8, 1'b1);
    wr(8'h03, 1'b1);
    sta(8'hE9, 1'b1);
    rd(8'h01, 1'b0);
    sto();
    chk_irq(1'b0);
    e = $urandom;
    @(negedge clk);
    port_change  = 1'b1;
    ep1_ack_load = 1'b1;
    ep1_ack_data = e;
    @(negedge clk);
    port_change  = 1'b0;
    ep1_ack_load = 1'b0;
    chk_irq(1'b1);
    sta(8'hE8, 1'b1);
    wr(8'h03, 1'b1);
    sta(8'hE9, 1'b1);
    rd(8'h06, 1'b0);
    sto();
    chk_irq(1'b1);
    sta(8'hE8, 1'b1);
    wr(8'h05, 1'b1);
    sta(8'hE9, 1'b1);
    rd(e, 1'b1);
    rd(e, 1'b0);
    sto();
    chk_irq(1'b0);
    for (int i = 0; i < 32; i++) begin
      @(negedge clk);
      rx_push = 1'b1;
      rx_data = 8'($urandom);
    end
    @(negedge clk);
    rx_push = 1'b0;
    cmp_bit(rx_ready, 1'b0, "receive fifo full");
    conclude();
  end

endmodule : test_usb_hub_uc_serial_fifo_port
